// [xcc_cfg.svh]
`ifndef XCC_CFG_SVH
`define XCC_CFG_SVH
`define XCC_NUM_OUT 8
`define XCC_SEL_W 3
`define XCC_SETUP_NS 200
`define XCC_PULSE_NS 300
`define XCC_HOLD_NS 200
`define XCC_CLK_NS 100
`define XCC_SETUP_CYC ((`XCC_SETUP_NS + `XCC_CLK_NS - 1) / `XCC_CLK_NS)
`define XCC_PULSE_CYC ((`XCC_PULSE_NS + `XCC_CLK_NS - 1) / `XCC_CLK_NS)
`define XCC_HOLD_CYC ((`XCC_HOLD_NS + `XCC_CLK_NS - 1) / `XCC_CLK_NS)
`define XCC_INIT_INPUT 3'h0
`endif

// [xcc_pkg.sv]
package xcc_pkg;
  typedef enum logic [4:0] {
    XCC_IDLE  = 5'h01,
    XCC_SETUP = 5'h02,
    XCC_PULSE = 5'h04,
    XCC_HOLD  = 5'h08,
    XCC_DONE  = 5'h10
  } xcc_state_e;

  typedef enum logic [1:0] {
    XCC_OP_STAGE  = 2'h0,
    XCC_OP_COMMIT = 2'h1,
    XCC_OP_INIT   = 2'h2
  } xcc_op_e;

  // Pin bundle toward the switch
  typedef struct packed {
    logic [2:0] output_select_bus;
    logic [2:0] input_select_bus;
    logic tristate;
    logic chip_select;
    logic stage_strobe;
    logic commit_strobe;
    logic initialize_pulse;
  } xcc_pins_s;
endpackage

// [xcc_ctrl.sv]
// Overview of operation
// - Controller puts the 3-bit output number on the output select bus.
// - Controller presents input number and enable bit as staging data.
// - Initialize pulse with chip select routes all outputs from input zero.
// - Tristate level during initialize enables or disables all outputs.
// - Stage each output with setup, select, strobe; commit after staging.
// - Tristate pin high marks addressed output high impedance.
`timescale 1ns/10ps
`include "xcc_cfg.svh"

module xcc_ctrl
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // User request
  input wire logic req_valid,
  input wire xcc_pkg::xcc_op_e req_op,
  input wire logic [2:0] req_output,
  input wire logic [2:0] req_input,
  input wire logic req_tristate,
  output logic req_ready,
  output logic req_done,
  // Switch pins
  output xcc_pkg::xcc_pins_s pins
);

  localparam int SETUP_CYC = `XCC_SETUP_CYC;
  localparam int PULSE_CYC = `XCC_PULSE_CYC;
  localparam int HOLD_CYC = `XCC_HOLD_CYC;

  xcc_pkg::xcc_state_e state;
  xcc_pkg::xcc_state_e next_state;
  xcc_pkg::xcc_op_e op;
  xcc_pkg::xcc_op_e next_op;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  xcc_pkg::xcc_pins_s next_pins;
  logic next_req_ready;
  logic next_req_done;

  function automatic logic [3:0] cyc4(input int n);
    cyc4 = 4'(n - 1);
  endfunction

  always_comb
  begin
    next_state = state;
    next_op = op;
    next_cnt = cnt;
    next_pins = pins;
    next_req_ready = 1'b0;
    next_req_done = 1'b0;
    unique case (state)
      xcc_pkg::XCC_IDLE:
      begin
        next_req_ready = 1'b1;
        if (req_valid && req_ready)
        begin
          next_req_ready = 1'b0;
          next_op = req_op;
          // Address, data and chip select are set together and settle before the strobe
          next_pins.output_select_bus = req_output;
          next_pins.input_select_bus = req_input;
          next_pins.tristate = req_tristate;
          next_pins.chip_select = 1'b1;
          next_cnt = cyc4(SETUP_CYC);
          next_state = xcc_pkg::XCC_SETUP;
        end
      end
      xcc_pkg::XCC_SETUP:
      begin
        if (cnt == 4'h0)
        begin
          next_pins.stage_strobe = (op == xcc_pkg::XCC_OP_STAGE);
          next_pins.commit_strobe = (op == xcc_pkg::XCC_OP_COMMIT);
          next_pins.initialize_pulse = (op == xcc_pkg::XCC_OP_INIT);
          next_cnt = cyc4(PULSE_CYC);
          next_state = xcc_pkg::XCC_PULSE;
        end
        else
          next_cnt = cnt - 4'h1;
      end
      xcc_pkg::XCC_PULSE:
      begin
        if (cnt == 4'h0)
        begin
          next_pins.stage_strobe = 1'b0;
          next_pins.commit_strobe = 1'b0;
          next_pins.initialize_pulse = 1'b0;
          next_cnt = cyc4(HOLD_CYC);
          next_state = xcc_pkg::XCC_HOLD;
        end
        else
          next_cnt = cnt - 4'h1;
      end
      xcc_pkg::XCC_HOLD:
      begin
        // Data and select held past the falling strobe
        if (cnt == 4'h0)
        begin
          next_pins.chip_select = 1'b0;
          next_req_done = 1'b1;
          next_state = xcc_pkg::XCC_DONE;
        end
        else
          next_cnt = cnt - 4'h1;
      end
      xcc_pkg::XCC_DONE:
      begin
        next_req_ready = 1'b1;
        next_state = xcc_pkg::XCC_IDLE;
      end
      default:
        next_state = xcc_pkg::XCC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= xcc_pkg::XCC_IDLE;
      op <= xcc_pkg::XCC_OP_STAGE;
      cnt <= 4'h0;
      pins <= '0;
      req_ready <= 1'b0;
      req_done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      op <= next_op;
      cnt <= next_cnt;
      pins <= next_pins;
      req_ready <= next_req_ready;
      req_done <= next_req_done;
    end
  end

  // Strobes only while chip select is high
  a_strobe_needs_cs: assert property (@(posedge clk) disable iff (!rst_n)
    (pins.stage_strobe || pins.commit_strobe || pins.initialize_pulse) |-> pins.chip_select)
    else $error("strobe without chip select");

  a_one_strobe: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot0({pins.stage_strobe, pins.commit_strobe, pins.initialize_pulse}))
    else $error("more than one strobe high");

  a_addr_stable_strobe: assert property (@(posedge clk) disable iff (!rst_n)
    pins.stage_strobe |-> $stable(pins.output_select_bus) && $stable(pins.input_select_bus)
      && $stable(pins.tristate))
    else $error("address moved under staging strobe");

  a_setup_before_rise: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pins.stage_strobe) |-> $past(pins.chip_select, 2))
    else $error("chip select not set up before strobe");

  a_pulse_width: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pins.commit_strobe) |-> pins.commit_strobe [*3] ##1 !pins.commit_strobe)
    else $error("commit pulse width wrong");

  a_init_width: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pins.initialize_pulse) |-> pins.initialize_pulse [*3] ##1 !pins.initialize_pulse)
    else $error("initialize pulse width wrong");

  a_tri_held_init: assert property (@(posedge clk) disable iff (!rst_n)
    pins.initialize_pulse |-> $stable(pins.tristate))
    else $error("tristate moved during initialize");

  a_done_after_req: assert property (@(posedge clk) disable iff (!rst_n)
    (req_valid && req_ready) |-> ##[8:8] req_done)
    else $error("request did not finish in eight cycles");

  // Pin handshake timing, cycle by cycle
  a_stage_width: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pins.stage_strobe) |-> pins.stage_strobe [*3] ##1 !pins.stage_strobe)
    else $error("staging pulse width wrong");

  a_setup_commit_init: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(pins.commit_strobe) || $rose(pins.initialize_pulse))
      |-> $past(pins.chip_select, 2))
    else $error("chip select not set up before commit or initialize");

  a_hold_after_strobe: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(pins.stage_strobe || pins.commit_strobe || pins.initialize_pulse)
      |-> pins.chip_select ##1 pins.chip_select)
    else $error("chip select dropped too soon after strobe");

  a_cs_ends_done: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(pins.chip_select) |-> req_done)
    else $error("chip select fell without done");

  a_bus_held_cs: assert property (@(posedge clk) disable iff (!rst_n)
    (pins.chip_select && $past(pins.chip_select)) |-> $stable(pins.output_select_bus)
      && $stable(pins.input_select_bus) && $stable(pins.tristate))
    else $error("select bus moved while chip select high");

  a_ready_only_idle: assert property (@(posedge clk) disable iff (!rst_n)
    req_ready |-> !pins.chip_select)
    else $error("ready raised during a transfer");

  c_stage: cover property (@(posedge clk) disable iff (!rst_n) $rose(pins.stage_strobe));
  c_commit: cover property (@(posedge clk) disable iff (!rst_n) $rose(pins.commit_strobe));
  c_init_tri: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(pins.initialize_pulse) && pins.tristate);
  c_back_to_back: cover property (@(posedge clk) disable iff (!rst_n)
    req_done ##1 (req_valid && req_ready));
  c_init_on: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(pins.initialize_pulse) && !pins.tristate);

endmodule

// [xcc_dev_model.sv]
`timescale 1ns/10ps
module xcc_dev_model
(
  // Switch pins
  input wire xcc_pkg::xcc_pins_s pins,
  // Rank contents, output n in bits 4n+3..4n: input number, then tristate
  output logic [31:0] load_rank,
  output logic [31:0] cfg_rank
);
  // Power-up contents are unknown until an initialize pulse
  initial
  begin
    load_rank = 32'hXXXXXXXX;
    cfg_rank = 32'hXXXXXXXX;
  end
  always @(posedge pins.stage_strobe)
    if (pins.chip_select)
      load_rank[pins.output_select_bus * 4 +: 4] = {pins.input_select_bus, pins.tristate};
  always @(posedge pins.commit_strobe)
    if (pins.chip_select)
      cfg_rank = load_rank;
  always @(posedge pins.initialize_pulse)
    if (pins.chip_select)
    begin
      load_rank = {8{3'h0, pins.tristate}};
      cfg_rank = {8{3'h0, pins.tristate}};
    end
endmodule

// [crosspoint_config_control_tb_top.sv]
`timescale 1ns/10ps
module crosspoint_config_control_tb_top;
  logic clk;
  logic rst_n;
  logic req_valid;
  xcc_pkg::xcc_op_e req_op;
  logic [2:0] req_output;
  logic [2:0] req_input;
  logic req_tristate;
  logic req_ready;
  logic req_done;
  xcc_pkg::xcc_pins_s pins;
  logic [31:0] load_rank;
  logic [31:0] cfg_rank;
  // Rows: {output, input, tristate} beside the nibble it should stage
  logic [6:0] rows [8] = '{7'h0A, 7'h1A, 7'h2D, 7'h3E, 7'h4A, 7'h53, 7'h64, 7'h77};
  logic [3:0] exp_nib [8] = '{4'hA, 4'hA, 4'hD, 4'hE, 4'hA, 4'h3, 4'h4, 4'h7};
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  xcc_ctrl dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
    .req_output(req_output), .req_input(req_input), .req_tristate(req_tristate),
    .req_ready(req_ready), .req_done(req_done), .pins(pins));
  xcc_dev_model model (.pins(pins), .load_rank(load_rank), .cfg_rank(cfg_rank));
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // Entered just after an edge; valid holds until the taking edge
  task automatic do_req(input xcc_pkg::xcc_op_e op, input logic [6:0] arg);
    int n;
    n = 0;
    req_op = op;
    {req_output, req_input, req_tristate} = arg;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (req_done !== 1'b1 && n < 12)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    // Done shows just after the seventh edge, sampled by the design at the eighth
    chk(n, 7);
    chk(pins.chip_select, 1'b0);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      results();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_op = xcc_pkg::XCC_OP_STAGE;
    req_output = 3'h0;
    req_input = 3'h0;
    req_tristate = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(32'(pins), 32'h0);
    rst_n = 1'b1;
    do_req(xcc_pkg::XCC_OP_INIT, 7'h7F);
    chk(load_rank, 32'h11111111);
    chk(cfg_rank, 32'h11111111);
    do_req(xcc_pkg::XCC_OP_INIT, 7'h00);
    chk(cfg_rank, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      do_req(xcc_pkg::XCC_OP_STAGE, rows[i]);
      chk(load_rank[i * 4 +: 4], exp_nib[i]);
      chk(cfg_rank, 32'h0);
    end
    do_req(xcc_pkg::XCC_OP_COMMIT, 7'h00);
    chk(cfg_rank, 32'h743AEDAA);
    // Restage over a committed output, then initialize clears both ranks
    do_req(xcc_pkg::XCC_OP_STAGE, 7'h2A);
    chk(cfg_rank, 32'h743AEDAA);
    chk(load_rank, 32'h743AEAAA);
    do_req(xcc_pkg::XCC_OP_INIT, 7'h00);
    chk(load_rank, 32'h0);
    chk(cfg_rank, 32'h0);
    // Reset in mid-commit; valid left high while busy must not be taken again
    req_op = xcc_pkg::XCC_OP_COMMIT;
    req_valid = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(pins.commit_strobe, 1'b1);
    req_valid = 1'b0;
    rst_n = 1'b0;
    #1;
    chk(32'(pins), 32'h0);
    chk(req_ready, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    do_req(xcc_pkg::XCC_OP_STAGE, 7'h35);
    chk(load_rank, 32'h00005000);
    chk(cfg_rank, 32'h0);
    results();
  end
endmodule
